// ### design/detector_regs.svh
// Register offsets, reset values and timing counts of the detector sequencer
`ifndef DETECTOR_REGS_SVH
`define DETECTOR_REGS_SVH

// ----------------------------------------------------------------
// Clock and oscillator timing
// ----------------------------------------------------------------
`define ACLK_MHZ 100
`define OSC_PERIOD_US 10500
`define OSC_CYC (`OSC_PERIOD_US * `ACLK_MHZ)
`define EMIT_US 105
`define EMIT_CYC (`EMIT_US * `ACLK_MHZ)
`define CHIRP_MS 10
`define CHIRP_CYC (`CHIRP_MS * 1000 * `ACLK_MHZ)

// ----------------------------------------------------------------
// Counts in oscillator cycles
// ----------------------------------------------------------------
`define PTT_PULSE_MS 252
`define PTT_PULSE_OSC ((`PTT_PULSE_MS * 1000) / `OSC_PERIOD_US)
`define BLINK_MS 500
`define HALF_OSC ((`BLINK_MS * 1000) / `OSC_PERIOD_US)
`define HORN_OFF2_MS 1500
`define HORN_ON_SLOTS 5
`define HORN_SLOTS (`HORN_ON_SLOTS + `HORN_OFF2_MS / `BLINK_MS)
`define CHECK_S 43
`define CHECK_OSC ((`CHECK_S * 1000000) / `OSC_PERIOD_US)
`define BATT_AT 0
`define CHAMBER_AT 1024
`define DEGR_AT (`CHECK_OSC / 2)
`define SENSE_MS 10000
`define SENSE_OSC ((`SENSE_MS * 1000) / `OSC_PERIOD_US)
`define HUSH_MIN 10
`define HUSH_OSC ((`HUSH_MIN * 60 * 1000000) / `OSC_PERIOD_US)
`define IO_SAMPLE_DIV 4
`define CONSEC_N 3
`define HUSH_EDGES 4

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_CTRL_ADDR 12'h000
`define REG_STATUS_ADDR 12'h004
`define CTRL_RESET 1'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### design/detector_pkg.sv
// Types shared by the detector sequencer
package detector_pkg;

  typedef enum logic [6:0] {
    ST_STANDBY  = 7'h01,
    ST_PTT_WAIT = 7'h02,
    ST_PTT      = 7'h04,
    ST_PTT_REL  = 7'h08,
    ST_PTT_TAIL = 7'h10,
    ST_DIAG     = 7'h20,
    ST_VENDOR   = 7'h40
  } mode_t;

  typedef enum logic [1:0] {
    SMP_SENSE   = 2'h0,
    SMP_CHAMBER = 2'h1,
    SMP_PTT     = 2'h2
  } sample_t;

endpackage

// ### design/consec_filter.sv
// Level filter that flips only after N equal consecutive samples
`timescale 1ns/1ps
`include "detector_regs.svh"

module consec_filter #(
  parameter int unsigned N = `CONSEC_N
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_en,
  input wire logic sample,
  input wire logic clear,
  output logic level
);

  logic [1:0] cnt_q;
  logic level_q;

  wire differs = sample != level_q;
  wire last = cnt_q == 2'(N - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_q <= 2'h0;
      level_q <= 1'h0;
    end else if (sample_en) begin
      if (!differs) begin
        cnt_q <= 2'h0;
      end else if (last) begin
        level_q <= sample;
        cnt_q <= 2'h0;
      end else begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  assign level = level_q;

endmodule

// ### design/detector_test_and_alarm_sequencer.sv
// Test, diagnostic and alarm sequencing of a photoelectric smoke detector
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "detector_regs.svh"

// Operation
// - Test press selects supervisory gain one oscillator cycle later
// - During push-to-test the emitter pulses every 252 ms
// - Three good test detections drive horn, interconnect, blink indicator
// - Failed test keeps indicator dark, horn silent, interconnect low
// - On release restore gain after one cycle, three more pulses, standby
// - Test falling edge starts ten-minute hush timer when hush enabled
// - Test held below ground one oscillator cycle enters diagnostic mode
// - Diagnostic mode never drives interconnect; high line routes amp out
// - Diagnostic: hush low normal gain on high pin, high the reverse
// - Diagnostic, line low: four hush rising edges enter vendor mode
// - Diagnostic, line high, hush low: feedback high adds gain boost
// - Diagnostic mode clocks from the external oscillator node edges
// - Diagnostic: first horn output shows the smoke integrator level
// - Diagnostic: indicator shows the low-battery comparator directly
// - Diagnostic: emitter pulses each cycle, strobe always on
// - Test released for one oscillator cycle leaves diagnostic mode
// - Alarms persist; local beats remote; both suppress warnings
// - Alarm horn: on, off, on, off, on half-second, then 1.5 s off
// - Local alarm blinks indicator each 0.5 s; remote keeps it dark
// - Chamber check every 43 s at supervisory gain must detect
// - Two failed chamber checks give a 10 ms chirp midway each 43 s
// - Battery checked every 43 s just before a one-cycle indicator flash; low chirps
// - Line sampled each fourth cycle; three highs plus one cycle alarm
// - Local alarm needs three detections and raises standby gain
module detector_test_and_alarm_sequencer
  import detector_pkg::*;
#(
  parameter logic [20:0] OSC_CYC = 21'(`OSC_CYC),
  parameter logic [13:0] EMIT_CYC = 14'(`EMIT_CYC),
  parameter logic [19:0] CHIRP_CYC = 20'(`CHIRP_CYC),
  parameter logic [15:0] HUSH_OSC = 16'(`HUSH_OSC)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic test_high,
  input wire logic test_below_gnd,
  input wire logic hush_in,
  input wire logic io_in,
  input wire logic feedback_in,
  input wire logic low_batt_in,
  input wire logic smoke_in,
  input wire logic oscillator_node,
  output logic emitter_drive,
  output logic strobe_on,
  output logic gain_supervisory,
  output logic gain_boost,
  output logic high_gain_cap_pin,
  output logic low_gain_cap_pin,
  output logic piezo_drive_a,
  output logic piezo_drive_b,
  output logic led_oe,
  output logic io_out,
  output logic io_oe,
  output logic timer_mode,
  output logic vendor_mode
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_s1_q, pin_s2_q;
  wire [7:0] pins_raw = {oscillator_node, smoke_in, low_batt_in,
                         feedback_in, io_in, hush_in, test_below_gnd,
                         test_high};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 8'h00;
      pin_s2_q <= 8'h00;
    end else begin
      pin_s1_q <= pins_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire test_hi = pin_s2_q[0];
  wire test_neg = pin_s2_q[1];
  wire hush_s = pin_s2_q[2];
  wire io_s = pin_s2_q[3];
  wire fb_s = pin_s2_q[4];
  wire batt_s = pin_s2_q[5];
  wire smoke_s = pin_s2_q[6];
  wire osc_s = pin_s2_q[7];

  // ----------------------------------------------------------------
  // Oscillator tick
  // ----------------------------------------------------------------
  mode_t mode_q, mode_d;
  logic [20:0] osc_cnt_q;
  logic osc_prev_q, neg_seen_q, hush_prev_q, test_prev_q;

  wire m_stby = mode_q == ST_STANDBY;
  wire m_wait = mode_q == ST_PTT_WAIT;
  wire m_ptt = mode_q == ST_PTT;
  wire m_rel = mode_q == ST_PTT_REL;
  wire m_tail = mode_q == ST_PTT_TAIL;
  wire m_diag = mode_q == ST_DIAG;
  wire diag_like = m_diag | (mode_q == ST_VENDOR);
  wire osc_wrap = osc_cnt_q == OSC_CYC - 21'h1;
  wire osc_rise = osc_s & ~osc_prev_q;
  wire tick = diag_like ? osc_rise : osc_wrap;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt_q <= 21'h0;
      osc_prev_q <= 1'h0;
      hush_prev_q <= 1'h0;
      test_prev_q <= 1'h0;
    end else begin
      osc_cnt_q <= osc_wrap ? 21'h0 : osc_cnt_q + 21'h1;
      osc_prev_q <= osc_s;
      hush_prev_q <= hush_s;
      test_prev_q <= test_hi;
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------
  logic [1:0] edge_cnt_q, tail_cnt_q, ptt_ok_q, fail_q, phase_q;
  logic [4:0] ivl_q;
  logic [13:0] emit_cnt_q;
  logic ptt_alarm_q;
  sample_t kind_q;

  wire hush_rise = hush_s & ~hush_prev_q;
  wire test_fall = ~test_hi & test_prev_q;
  wire diag_go = tick & test_neg & neg_seen_q & ~diag_like;
  wire diag_quit = tick & ~test_neg & ~neg_seen_q & diag_like;
  wire vend_go = m_diag & ~io_s & hush_rise &
                 (edge_cnt_q == 2'(`HUSH_EDGES - 1));
  wire smp = emit_cnt_q == 14'h1;
  wire tail_done = m_tail & smp & (tail_cnt_q == 2'h3);

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      ST_STANDBY: begin
        if (test_hi) mode_d = ST_PTT_WAIT;
      end
      ST_PTT_WAIT: begin
        if (!test_hi) mode_d = ST_STANDBY;
        else if (tick) mode_d = ST_PTT;
      end
      ST_PTT: begin
        if (!test_hi) mode_d = ST_PTT_REL;
      end
      ST_PTT_REL: begin
        if (tick) mode_d = ST_PTT_TAIL;
      end
      ST_PTT_TAIL: begin
        if (tail_done) mode_d = ST_STANDBY;
      end
      ST_DIAG: begin
        if (diag_quit) mode_d = ST_STANDBY;
        else if (vend_go) mode_d = ST_VENDOR;
      end
      ST_VENDOR: begin
        if (diag_quit) mode_d = ST_STANDBY;
      end
      default: mode_d = ST_STANDBY;
    endcase
    if (diag_go) mode_d = ST_DIAG;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= ST_STANDBY;
      neg_seen_q <= 1'h0;
      edge_cnt_q <= 2'h0;
    end else begin
      mode_q <= mode_d;
      if (tick) neg_seen_q <= test_neg;
      if (!m_diag || io_s) edge_cnt_q <= 2'h0;
      else if (hush_rise) edge_cnt_q <= edge_cnt_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Emitter pulse scheduling
  // ----------------------------------------------------------------
  logic [11:0] per_q;
  logic [9:0] sense_q;
  logic checks_en_q;
  logic local_alarm, remote_alarm, alarm_any;

  wire quiet = m_stby & ~alarm_any;
  wire ptt_slot = (m_ptt | m_tail) & tick & (ivl_q == 5'h0);
  wire chk_slot = quiet & checks_en_q & tick &
                  (per_q == 12'(`CHAMBER_AT));
  wire batt_slot = quiet & checks_en_q & tick &
                   (per_q == 12'(`BATT_AT));
  wire sense_slot = m_stby & tick & (sense_q == 10'h0) & ~chk_slot;
  wire pulse_req = ptt_slot | chk_slot | sense_slot |
                   (diag_like & tick);
  wire emitting = emit_cnt_q != 14'h0;
  wire smp_sense = smp & (kind_q == SMP_SENSE);
  wire smp_chk = smp & (kind_q == SMP_CHAMBER);
  wire smp_ptt = smp & (kind_q == SMP_PTT) & m_ptt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emit_cnt_q <= 14'h0;
      kind_q <= SMP_SENSE;
      ivl_q <= 5'h0;
      tail_cnt_q <= 2'h0;
      per_q <= 12'h0;
      sense_q <= 10'h0;
      phase_q <= 2'h0;
    end else begin
      if (pulse_req) begin
        emit_cnt_q <= EMIT_CYC;
        kind_q <= chk_slot ? SMP_CHAMBER : ptt_slot ? SMP_PTT : SMP_SENSE;
      end else if (emitting) begin
        emit_cnt_q <= emit_cnt_q - 14'h1;
      end
      if (m_wait || m_rel) ivl_q <= 5'h0;
      else if (tick && (m_ptt || m_tail))
        ivl_q <= (ivl_q == 5'(`PTT_PULSE_OSC - 1)) ? 5'h0 : ivl_q + 5'h1;
      if (m_rel) tail_cnt_q <= 2'h0;
      else if (ptt_slot && m_tail) tail_cnt_q <= tail_cnt_q + 2'h1;
      if (tick && !diag_like) begin
        per_q <= (per_q == 12'(`CHECK_OSC - 1)) ? 12'h0 : per_q + 12'h1;
        sense_q <= (sense_q == 10'(`SENSE_OSC - 1)) ? 10'h0 :
                   sense_q + 10'h1;
      end
      if (tick) phase_q <= phase_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Detection: push-to-test, smoke integrator, interconnect filter
  // ----------------------------------------------------------------
  logic smoke_int, io_armed, remote_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || m_stby || diag_like) begin
      ptt_ok_q <= 2'h0;
      ptt_alarm_q <= 1'h0;
    end else if (smp_ptt) begin
      if (!smoke_s) begin
        ptt_ok_q <= 2'h0;
        ptt_alarm_q <= 1'h0;
      end else if (ptt_ok_q == 2'h2) begin
        ptt_alarm_q <= 1'h1;
      end else begin
        ptt_ok_q <= ptt_ok_q + 2'h1;
      end
    end
  end

  // Three in a row either way; also the diagnostic integrator output
  consec_filter u_smoke (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_en(smp_sense),
    .sample(smoke_s),
    .clear(1'b0),
    .level(smoke_int)
  );

  // Any low level on the line drops the partial count at once
  consec_filter u_line (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_en(tick && phase_q == 2'(`IO_SAMPLE_DIV - 1)),
    .sample(io_s),
    .clear(!io_s || local_alarm || !m_stby),
    .level(io_armed)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || !io_armed) remote_q <= 1'h0;
    else if (tick) remote_q <= 1'h1;
  end

  assign local_alarm = smoke_int & m_stby;
  assign remote_alarm = remote_q & m_stby & ~local_alarm;
  assign alarm_any = local_alarm | remote_alarm | ptt_alarm_q;

  // ----------------------------------------------------------------
  // Supervision, hush timer, horn pattern
  // ----------------------------------------------------------------
  logic [15:0] hush_q;
  logic [19:0] chirp_q;
  logic [5:0] half_q;
  logic [2:0] slot_q;
  logic batt_low_q, blink_q, flash_q;

  wire degraded = fail_q == 2'h2;
  wire degr_slot = quiet & tick & degraded &
                   (per_q == 12'(`DEGR_AT));
  wire chirp_req = (batt_slot & batt_s) | degr_slot;
  wire half_wrap = half_q == 6'(`HALF_OSC - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hush_q <= 16'h0;
      fail_q <= 2'h0;
      batt_low_q <= 1'h0;
      chirp_q <= 20'h0;
      flash_q <= 1'h0;
    end else begin
      if (test_fall && hush_s) hush_q <= HUSH_OSC;
      else if (tick && hush_q != 16'h0) hush_q <= hush_q - 16'h1;
      if (smp_chk)
        fail_q <= smoke_s ? 2'h0 : degraded ? fail_q : fail_q + 2'h1;
      if (batt_slot) batt_low_q <= batt_s;
      if (chirp_req) chirp_q <= CHIRP_CYC;
      else if (chirp_q != 20'h0) chirp_q <= chirp_q - 20'h1;
      if (tick) flash_q <= batt_slot;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !alarm_any) begin
      half_q <= 6'h0;
      slot_q <= 3'h0;
      blink_q <= 1'h0;
    end else if (tick) begin
      half_q <= half_wrap ? 6'h0 : half_q + 6'h1;
      if (half_wrap)
        slot_q <= (slot_q == 3'(`HORN_SLOTS - 1)) ? 3'h0 : slot_q + 3'h1;
      blink_q <= half_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  wire horn_pat = alarm_any & ~slot_q[0] &
                  (slot_q < 3'(`HORN_ON_SLOTS));
  wire horn = horn_pat | (chirp_q != 20'h0);
  wire led_d = diag_like ? batt_s : ~remote_alarm &
               (flash_q | ((local_alarm | ptt_alarm_q) & blink_q));
  wire io_d = ~diag_like & (local_alarm | ptt_alarm_q);
  wire gain_d = m_ptt | m_rel | (emitting & kind_q == SMP_CHAMBER) |
                (diag_like & io_s & hush_s);
  wire boost_d = local_alarm |
                 (diag_like & io_s & ~hush_s & fb_s);
  wire c1_d = diag_like & io_s & ~hush_s & emitting;
  wire c2_d = diag_like & io_s & hush_s & emitting;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emitter_drive <= 1'h0;
      strobe_on <= 1'h0;
      gain_supervisory <= 1'h0;
      gain_boost <= 1'h0;
      high_gain_cap_pin <= 1'h0;
      low_gain_cap_pin <= 1'h0;
      piezo_drive_a <= 1'h0;
      piezo_drive_b <= 1'h0;
      led_oe <= 1'h0;
      io_out <= 1'h0;
      io_oe <= 1'h0;
      timer_mode <= 1'h0;
      vendor_mode <= 1'h0;
    end else begin
      emitter_drive <= emitting;
      strobe_on <= diag_like | emitting;
      gain_supervisory <= gain_d;
      gain_boost <= boost_d;
      high_gain_cap_pin <= c1_d;
      low_gain_cap_pin <= c2_d;
      piezo_drive_a <= diag_like ? smoke_int : horn;
      piezo_drive_b <= ~diag_like & horn;
      led_oe <= led_d;
      io_out <= io_d;
      io_oe <= io_d;
      timer_mode <= hush_q != 16'h0;
      vendor_mode <= mode_q == ST_VENDOR;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite register slave
  // ----------------------------------------------------------------
  logic aw_hold_q, w_hold_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  wire [7:0] status = {mode_q == ST_VENDOR, m_diag, hush_q != 16'h0,
                       degraded, batt_low_q, remote_alarm, local_alarm,
                       ptt_alarm_q};
  wire wr_fire = aw_hold_q & w_hold_q & ~bvalid;
  wire wr_ctrl = awaddr_q == `REG_CTRL_ADDR;
  wire wr_ok = wr_ctrl | (awaddr_q == `REG_STATUS_ADDR);
  wire rd_ctrl = araddr == `REG_CTRL_ADDR;
  wire rd_stat = araddr == `REG_STATUS_ADDR;
  wire [31:0] rd_data = rd_ctrl ? {31'h0, checks_en_q} :
                        rd_stat ? {24'h0, status} : 32'h0;

  assign awready = ~aw_hold_q & ~bvalid;
  assign wready = ~w_hold_q & ~bvalid;
  assign arready = ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'h0;
      w_hold_q <= 1'h0;
      awaddr_q <= 12'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid <= 1'h0;
      bresp <= `RESP_OKAY;
      checks_en_q <= `CTRL_RESET;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'h1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'h1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'h0;
        w_hold_q <= 1'h0;
        bvalid <= 1'h1;
        bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_ctrl && wstrb_q[0]) checks_en_q <= wdata_q[0];
      end else if (bready) begin
        bvalid <= 1'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'h0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'h1;
      rdata <= rd_data;
      rresp <= (rd_ctrl || rd_stat) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ptt_gain_a: assert property (
    (m_wait && tick && test_hi && !diag_go)
    |=> m_ptt ##1 gain_supervisory)
    else $error("supervisory gain late after test press");
  emit_pulse_a: assert property (
    pulse_req |-> ##2 emitter_drive [*2])
    else $error("emitter pulse missing after request");
  ptt_pass_a: assert property (
    $rose(ptt_alarm_q) |-> $past(ptt_ok_q) == 2'h2 && $past(smp_ptt))
    else $error("test alarm without three detections");
  ptt_quiet_a: assert property (
    (m_ptt && !ptt_alarm_q && !local_alarm) |=> !io_out && !io_oe)
    else $error("interconnect driven during failed test");
  tail_exit_a: assert property (
    (tail_done && !diag_go) |=> m_stby)
    else $error("test mode not left after tail pulses");
  hush_start_a: assert property (
    (test_fall && hush_s) |=> hush_q == HUSH_OSC ##1 timer_mode)
    else $error("hush timer not started");
  diag_io_a: assert property (
    diag_like |=> !io_oe)
    else $error("interconnect driven in diagnostic mode");
  diag_route_a: assert property (
    (diag_like && io_s && hush_s) |=> !high_gain_cap_pin)
    else $error("amplifier routed to wrong gain pin");
  vendor_go_a: assert property (
    (vend_go && !diag_quit) |=> mode_q == ST_VENDOR ##1 vendor_mode)
    else $error("vendor mode not entered");
  diag_strobe_a: assert property (
    diag_like |=> strobe_on)
    else $error("strobe off in diagnostic mode");
  warn_block_a: assert property (
    (alarm_any && chirp_q == 20'h0) |=> chirp_q == 20'h0)
    else $error("warning chirp during alarm");
  horn_gap_a: assert property (
    (alarm_any && slot_q[0] && chirp_q == 20'h0) |=> !piezo_drive_a)
    else $error("horn sounding in an off slot");
  remote_led_a: assert property (
    remote_alarm |=> !led_oe)
    else $error("indicator lit during remote alarm");
  local_gain_a: assert property (
    local_alarm |=> gain_boost)
    else $error("standby gain not raised in local alarm");

  ptt_pass_c: cover property ($rose(ptt_alarm_q));
  diag_enter_c: cover property (diag_go);
  remote_c: cover property ($rose(remote_alarm));
  degraded_c: cover property (degr_slot);

endmodule

// ### verification/remote_unit.sv
// Model of another detector unit sharing the interconnect line
`timescale 1ns/1ps
module remote_unit (
  input wire logic alarm,
  input wire logic dut_out,
  input wire logic dut_oe,
  output logic line
);
  // ------
  // Wired line, held low by its pull-down when nobody drives it
  // ------
  assign line = (dut_oe & dut_out) | alarm;
endmodule

// ### verification/detector_test_and_alarm_sequencer_bench.sv
// Self-checking bench of the detector sequencer
`timescale 1ns/1ps
module detector_test_and_alarm_sequencer_bench;
  localparam int OSC = 40;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, alarm;
  logic awready, wready, bvalid, arready, rvalid, io_line, io_out, io_oe;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic test_high, test_below_gnd, hush_in, low_batt_in, smoke_in;
  logic oscillator_node, emitter_drive, strobe_on, gain_supervisory;
  logic piezo_drive_a, piezo_drive_b, led_oe, timer_mode;
  logic led_any, horn_any, io_any, em_prev;
  logic [4:0] div = 5'h00;
  logic feedback_in, gain_boost;
  int fails, n_checks, cyc, em_n;

  detector_test_and_alarm_sequencer #(.OSC_CYC(21'h28), .EMIT_CYC(14'h4),
    .CHIRP_CYC(20'h14), .HUSH_OSC(16'hA))
  detector_test_and_alarm_sequencer_inst (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .test_high(test_high), .test_below_gnd(test_below_gnd),
    .hush_in(hush_in), .io_in(io_line), .feedback_in(feedback_in),
    .low_batt_in(low_batt_in), .smoke_in(smoke_in),
    .oscillator_node(oscillator_node), .emitter_drive(emitter_drive),
    .strobe_on(strobe_on), .gain_supervisory(gain_supervisory),
    .gain_boost(gain_boost), .high_gain_cap_pin(), .low_gain_cap_pin(),
    .piezo_drive_a(piezo_drive_a), .piezo_drive_b(piezo_drive_b),
    .led_oe(led_oe), .io_out(io_out), .io_oe(io_oe),
    .timer_mode(timer_mode), .vendor_mode());

  remote_unit remote_unit_inst (.alarm(alarm), .dut_out(io_out),
    .dut_oe(io_oe), .line(io_line));

  // ------
  // Clock, tester oscillator, timeout and tasks
  // ------
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    div <= div + 5'h01;
    oscillator_node <= div[4];
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      results();
    end
  end

  task results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task check_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask

  task ticks(input int n);
    repeat (n * OSC) @(posedge aclk);
  endtask

  task watch(input int n);
    led_any = 1'h0;
    horn_any = 1'h0;
    io_any = 1'h0;
    em_n = 0;
    repeat (n * OSC) begin
      @(posedge aclk);
      led_any |= led_oe;
      horn_any |= piezo_drive_a | piezo_drive_b;
      io_any |= io_oe;
      if (emitter_drive && !em_prev) em_n = em_n + 1;
      em_prev = emitter_drive;
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    check_word({30'h0, bresp}, {30'h0, er});
  endtask

  task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0;
    check_word(rdata, d);
    check_word({30'h0, rresp}, {30'h0, er});
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, alarm} = '0;
    {awaddr, araddr, wdata, em_prev, feedback_in} = '0;
    {test_high, test_below_gnd, hush_in, low_batt_in, smoke_in} = '0;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd(12'h000, 32'h1, 2'h0);
    rd(12'h008, 32'h0, 2'h2);
    wr(12'h00C, 32'h0, 2'h2);
    wr(12'h000, 32'h0, 2'h0);
    wr(12'h004, 32'hFF, 2'h0);
    rd(12'h000, 32'h0, 2'h0);
    $display("register test done");
    test_below_gnd <= 1'h1;
    ticks(4);
    rd(12'h004, 32'h40, 2'h0);
    alarm <= 1'h1;
    low_batt_in <= 1'h1;
    smoke_in <= 1'h1;
    feedback_in <= 1'h1;
    watch(6);
    check_bit(io_any, 1'h0);
    check_bit(em_n > 4, 1'h1);
    check_bit(strobe_on, 1'h1);
    check_bit(led_oe, 1'h1);
    check_bit(piezo_drive_a, 1'h1);
    check_bit(gain_boost, 1'h1);
    {alarm, low_batt_in, smoke_in, feedback_in} <= 4'h0;
    ticks(6);
    check_bit(piezo_drive_a, 1'h0);
    check_bit(led_oe, 1'h0);
    repeat (4) begin
      hush_in <= 1'h1;
      ticks(1);
      hush_in <= 1'h0;
      ticks(1);
    end
    rd(12'h004, 32'h80, 2'h0);
    test_below_gnd <= 1'h0;
    ticks(4);
    rd(12'h004, 32'h0, 2'h0);
    $display("diagnostic test done");
    hush_in <= 1'h1;
    test_high <= 1'h1;
    ticks(3);
    check_bit(gain_supervisory, 1'h1);
    watch(75);
    check_bit(led_any | horn_any | io_any, 1'h0);
    check_word(em_n, 32'h3);
    test_high <= 1'h0;
    ticks(3);
    check_bit(gain_supervisory, 1'h0);
    check_bit(timer_mode, 1'h1);
    ticks(80);
    rd(12'h004, 32'h0, 2'h0);
    hush_in <= 1'h0;
    test_high <= 1'h1;
    smoke_in <= 1'h1;
    watch(75);
    check_bit(io_any & horn_any, 1'h1);
    {test_high, smoke_in} <= 2'h0;
    ticks(80);
    rd(12'h004, 32'h0, 2'h0);
    $display("push test done");
    alarm <= 1'h1;
    ticks(6);
    alarm <= 1'h0;
    ticks(2);
    rd(12'h004, 32'h0, 2'h0);
    alarm <= 1'h1;
    ticks(20);
    rd(12'h004, 32'h4, 2'h0);
    watch(200);
    check_bit(led_any, 1'h0);
    check_bit(horn_any, 1'h1);
    alarm <= 1'h0;
    ticks(2);
    rd(12'h004, 32'h0, 2'h0);
    $display("remote alarm test done");
    results();
  end
endmodule
